// ---- rftor_pkg.sv ----
// Package with register map, field layout, reset values and bus carriers of the RF test override bank
// Contract
// - Mixer test bit forces static DC outputs
// - Polarity field selects I and Q signs
// - Routing active: power-down and mode from interface
// - No routing: power-down and mode MSB forced
// - Filter-route bit connects test module to filter
// - ADC-route bit connects test module to ADC
// - Three charge pump test bits, reset zero
// - Sample output drives lock, data, clock pins
// - Rotation field picks ADC input rotation order
// - Dither enable resets to one
// - Comparator bit enables frequency comparator output
// - Chop, shaping, rotation disable bits reset zero
// - VGA override sets first coupler from bit
// - VGA override sets second coupler from field
// - Three stage override fields applied under override
// - Status shows live lock, clock, data levels
package rftor_pkg;

	// Bus widths
	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [6:0] IDX_CP_MIXER_TEST_CTRL = 7'h24;
	localparam logic [6:0] IDX_ADC_TEST_CTRL = 7'h25;
	localparam logic [6:0] IDX_VGA_COUPLER_OVERRIDE = 7'h26;
	localparam logic [6:0] IDX_VGA_STAGE_OVERRIDE = 7'h27;
	localparam logic [6:0] IDX_TESTMOD_IFACE = 7'h28;
	localparam logic [6:0] IDX_PIN_STATUS = 7'h40;

	// Charge pump and mixer control fields
	localparam int POS_PUMP_NORMAL_OFF = 7;
	localparam int POS_PUMP_FORCE_UP = 6;
	localparam int POS_PUMP_FORCE_DOWN = 5;
	localparam int POS_MIXER_POLARITY_HI = 4;
	localparam int POS_MIXER_POLARITY_LO = 3;
	localparam int POS_MIXER_DC_TEST_EN = 2;
	localparam int POS_TESTMOD_TO_FILTER_EN = 1;
	localparam int POS_TESTMOD_TO_ADC_EN = 0;

	// ADC test fields
	localparam int POS_FREQ_COMP_EN = 7;
	localparam int POS_DITHER_EN = 6;
	localparam int POS_ADC_SAMPLE_OUT = 5;
	localparam int POS_CHOP_OFF = 4;
	localparam int POS_SHAPING_OFF = 3;
	localparam int POS_CM_ROTATION_OFF = 2;

	// VGA fields
	localparam int POS_VGA_OVERRIDE = 3;
	localparam int POS_COUPLER_ONE = 2;

	// Test module interface fields
	localparam int POS_TESTMOD_PD = 3;

	// Status fields
	localparam int POS_STAT_LOCK = 2;
	localparam int POS_STAT_DATA_CLOCK_PIN = 1;
	localparam int POS_STAT_DATA = 0;

	// Values after reset
	localparam logic [7:0] RST_CP_MIXER_TEST_CTRL = 8'h00;
	localparam logic [7:0] RST_ADC_TEST_CTRL = 8'h40;
	localparam logic [3:0] RST_VGA_COUPLER_OVERRIDE = 4'h0;
	localparam logic [5:0] RST_VGA_STAGE_OVERRIDE = 6'h00;
	localparam logic [3:0] RST_TESTMOD_IFACE = 4'h0;

	// ADC sampling clock: half period in system cycles
	localparam int ADC_HALF_PERIOD_CYCLES = 4;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Rotation modes
	typedef enum logic [1:0] {ROT_NATURAL, ROT_GRAY, ROT_FIXED, ROT_ALTERNATE} rftor_rot_type;

	// Master to slave
	typedef struct packed {
		logic awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [AXI_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic rready;
	} rftor_axi_req_type;

	// Slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} rftor_axi_resp_type;

endpackage : rftor_pkg

// ---- rftor_regs.sv ----
// RF test override register bank with AXI4-Lite slave and pin test muxing
`timescale 1ns/100ps
module rftor_regs import rftor_pkg::*; #(
	parameter int ADC_HALF_PERIOD = ADC_HALF_PERIOD_CYCLES
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Register bus
	input wire rftor_axi_req_type AXI_REQ,
	output rftor_axi_resp_type AXI_RESP,
	// Charge pump
	output logic PUMP_NORMAL_OFF,
	output logic PUMP_FORCE_UP,
	output logic PUMP_FORCE_DOWN,
	// Mixer
	output logic MIXER_DC_TEST_EN,
	output logic MIXER_I_POSITIVE,
	output logic MIXER_Q_POSITIVE,
	// Analog test module
	output logic TESTMOD_TO_FILTER_EN,
	output logic TESTMOD_TO_ADC_EN,
	output logic TESTMOD_POWERDOWN,
	output logic [2:0] TESTMOD_MODE,
	// ADC and phase detector
	output logic FREQ_COMP_OUT_EN,
	output logic SIGMA_DELTA_DITHER_EN,
	output logic INTEGRATOR_CHOP_OFF,
	output logic FEEDBACK_SHAPING_OFF,
	output logic COMMON_MODE_ROTATION_OFF,
	output logic [1:0] ADC_ROTATION_POS,
	output logic ADC_CLK_OUT,
	input wire logic [1:0] ADC_SAMPLE,
	// VGA
	output logic VGA_OVERRIDE_EN,
	output logic COUPLER_ONE_VALUE,
	output logic [1:0] COUPLER_TWO_VALUE,
	output logic [1:0] GAIN_STAGE_ONE_VALUE,
	output logic [1:0] GAIN_STAGE_TWO_VALUE,
	output logic [1:0] GAIN_STAGE_THREE_VALUE,
	// Normal pin sources
	input wire logic LOCK_NORMAL,
	input wire logic LOCK_NORMAL_OE,
	input wire logic DATA_CLOCK_PIN_NORMAL,
	input wire logic DATA_CLOCK_PIN_NORMAL_OE,
	input wire logic DATA_NORMAL,
	input wire logic DATA_NORMAL_OE,
	// Pins
	input wire logic LOCK_PIN_I,
	output logic LOCK_PIN_O,
	output logic LOCK_PIN_OE,
	input wire logic DATA_CLOCK_PIN_I,
	output logic DATA_CLOCK_PIN_O,
	output logic DATA_CLOCK_PIN_OE,
	input wire logic SERIAL_DATA_PIN_I,
	output logic SERIAL_DATA_PIN_O,
	output logic SERIAL_DATA_PIN_OE
);

	// Stored registers
	logic [7:0] cp_mixer_reg, cp_mixer_next;
	logic [7:0] adc_test_reg, adc_test_next;
	logic [3:0] vga_coupler_reg, vga_coupler_next;
	logic [5:0] vga_stage_reg, vga_stage_next;
	logic [3:0] iface_reg, iface_next;
	// Write channel state
	logic aw_held_reg, aw_held_next;
	logic [6:0] aw_idx_reg, aw_idx_next;
	logic aw_bad_reg, aw_bad_next;
	logic w_held_reg, w_held_next;
	logic [7:0] w_data_reg, w_data_next;
	logic w_lane_reg, w_lane_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	// Read channel state
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	// ADC clock divider and rotation
	logic [15:0] div_cnt_reg, div_cnt_next;
	logic adc_clk_reg, adc_clk_next;
	logic [1:0] rot_step_reg, rot_step_next;
	// Decode helpers
	logic routing_on;
	logic sample_out;
	logic do_write;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [6:0] ar_idx;

	// Routing of test module is live when either route bit is set
	assign routing_on = cp_mixer_reg[POS_TESTMOD_TO_FILTER_EN] | cp_mixer_reg[POS_TESTMOD_TO_ADC_EN];
	assign sample_out = adc_test_reg[POS_ADC_SAMPLE_OUT];
	// Write commits once address and data are both held and no answer is pending
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign ar_idx = AXI_REQ.araddr[8:2];
	// Rotation order lookup
	function automatic logic [1:0] rot_pos(input logic [1:0] mode, input logic [1:0] step);
		case (rftor_rot_type'(mode))
			ROT_NATURAL: rot_pos = step;
			// Order 00 10 11 01 is the step in Gray code with its bits swapped
			ROT_GRAY: rot_pos = {step[1] ^ step[0], step[1]};
			ROT_FIXED: rot_pos = 2'h0;
			ROT_ALTERNATE: rot_pos = step[0] ? 2'h2 : 2'h0;
			default: rot_pos = 2'h0;
		endcase
	endfunction : rot_pos
	// Read mux; status bits are sampled live from the pins
	always_comb begin
		rd_hit = (AXI_REQ.araddr[AXI_ADDR_W-1:9] == '0);
		rd_byte = 8'h00;
		case (ar_idx)
			IDX_CP_MIXER_TEST_CTRL: rd_byte = cp_mixer_reg;
			IDX_ADC_TEST_CTRL: rd_byte = adc_test_reg;
			IDX_VGA_COUPLER_OVERRIDE: rd_byte = {4'h0, vga_coupler_reg}; // Reserved bits read zero
			IDX_VGA_STAGE_OVERRIDE: rd_byte = {2'h0, vga_stage_reg};
			IDX_TESTMOD_IFACE: rd_byte = {4'h0, iface_reg};
			IDX_PIN_STATUS: rd_byte = {5'h00, LOCK_PIN_I, DATA_CLOCK_PIN_I, SERIAL_DATA_PIN_I};
			default: rd_hit = 1'b0; // Unmapped answers SLVERR
		endcase
	end

	// Bus channels and register writes, next state
	always_comb begin
		cp_mixer_next = cp_mixer_reg;
		adc_test_next = adc_test_reg;
		vga_coupler_next = vga_coupler_reg;
		vga_stage_next = vga_stage_reg;
		iface_next = iface_reg;
		aw_held_next = aw_held_reg;
		aw_idx_next = aw_idx_reg;
		aw_bad_next = aw_bad_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_lane_next = w_lane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		// Address and data taken in either order
		if (AXI_REQ.awvalid && !aw_held_reg) begin
			aw_held_next = 1'b1;
			aw_idx_next = AXI_REQ.awaddr[8:2];
			aw_bad_next = (AXI_REQ.awaddr[AXI_ADDR_W-1:9] != '0);
		end
		if (AXI_REQ.wvalid && !w_held_reg) begin
			w_held_next = 1'b1;
			w_data_next = AXI_REQ.wdata[7:0];
			w_lane_next = AXI_REQ.wstrb[0];
		end
		// Commit the write and raise the answer
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			if (aw_bad_reg) begin
				bresp_next = RESP_SLVERR;
			end else begin
				case (aw_idx_reg)
					IDX_CP_MIXER_TEST_CTRL: if (w_lane_reg) cp_mixer_next = w_data_reg;
					IDX_ADC_TEST_CTRL: if (w_lane_reg) adc_test_next = w_data_reg;
					IDX_VGA_COUPLER_OVERRIDE: if (w_lane_reg) vga_coupler_next = w_data_reg[3:0];
					IDX_VGA_STAGE_OVERRIDE: if (w_lane_reg) vga_stage_next = w_data_reg[5:0];
					IDX_TESTMOD_IFACE: if (w_lane_reg) iface_next = w_data_reg[3:0];
					IDX_PIN_STATUS: bresp_next = RESP_OKAY; // Read-only, write ignored
					default: bresp_next = RESP_SLVERR;
				endcase
			end
		end else if (bvalid_reg && AXI_REQ.bready) begin
			bvalid_next = 1'b0;
		end
		// Read answered one cycle after the address is taken
		if (!rvalid_reg && AXI_REQ.arvalid) begin
			rvalid_next = 1'b1;
			rdata_next = {24'h000000, rd_byte};
			rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && AXI_REQ.rready) begin
			rvalid_next = 1'b0;
		end
	end

	// Bus and register flops
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cp_mixer_reg <= RST_CP_MIXER_TEST_CTRL;
			adc_test_reg <= RST_ADC_TEST_CTRL;
			vga_coupler_reg <= RST_VGA_COUPLER_OVERRIDE;
			vga_stage_reg <= RST_VGA_STAGE_OVERRIDE;
			iface_reg <= RST_TESTMOD_IFACE;
			aw_held_reg <= 1'b0;
			aw_idx_reg <= 7'h00;
			aw_bad_reg <= 1'b0;
			w_held_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else begin
			cp_mixer_reg <= cp_mixer_next;
			adc_test_reg <= adc_test_next;
			vga_coupler_reg <= vga_coupler_next;
			vga_stage_reg <= vga_stage_next;
			iface_reg <= iface_next;
			aw_held_reg <= aw_held_next;
			aw_idx_reg <= aw_idx_next;
			aw_bad_reg <= aw_bad_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_lane_reg <= w_lane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// Bus outputs; ready held low while a channel's word is parked
	always_comb begin
		AXI_RESP.awready = !aw_held_reg;
		AXI_RESP.wready = !w_held_reg;
		AXI_RESP.bvalid = bvalid_reg;
		AXI_RESP.bresp = bresp_reg;
		AXI_RESP.arready = !rvalid_reg;
		AXI_RESP.rvalid = rvalid_reg;
		AXI_RESP.rdata = rdata_reg;
		AXI_RESP.rresp = rresp_reg;
	end

	// ADC clock divider and rotation step, next state
	always_comb begin
		div_cnt_next = div_cnt_reg + 16'h0001;
		adc_clk_next = adc_clk_reg;
		rot_step_next = rot_step_reg;
		if (div_cnt_reg >= 16'(ADC_HALF_PERIOD - 1)) begin
			div_cnt_next = 16'h0000;
			adc_clk_next = !adc_clk_reg;
			// Step rotation on each rising ADC clock edge
			if (!adc_clk_reg) begin
				rot_step_next = rot_step_reg + 2'h1;
			end
		end
	end
	// ADC clock flops
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			div_cnt_reg <= 16'h0000;
			adc_clk_reg <= 1'b0;
			rot_step_reg <= 2'h0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			adc_clk_reg <= adc_clk_next;
			rot_step_reg <= rot_step_next;
		end
	end

	// Analog control outputs from the stored fields, some gated or forced as noted below
	always_comb begin
		PUMP_NORMAL_OFF = cp_mixer_reg[POS_PUMP_NORMAL_OFF];
		PUMP_FORCE_UP = cp_mixer_reg[POS_PUMP_FORCE_UP];
		PUMP_FORCE_DOWN = cp_mixer_reg[POS_PUMP_FORCE_DOWN];
		MIXER_DC_TEST_EN = cp_mixer_reg[POS_MIXER_DC_TEST_EN];
		// Polarity only meaningful under DC test; idle low otherwise
		MIXER_I_POSITIVE = MIXER_DC_TEST_EN & cp_mixer_reg[POS_MIXER_POLARITY_HI];
		MIXER_Q_POSITIVE = MIXER_DC_TEST_EN & cp_mixer_reg[POS_MIXER_POLARITY_LO];
		TESTMOD_TO_FILTER_EN = cp_mixer_reg[POS_TESTMOD_TO_FILTER_EN];
		TESTMOD_TO_ADC_EN = cp_mixer_reg[POS_TESTMOD_TO_ADC_EN];
		if (routing_on) begin
			TESTMOD_POWERDOWN = iface_reg[POS_TESTMOD_PD];
			TESTMOD_MODE = iface_reg[2:0];
		end else begin
			// Keep the test module asleep when nothing is routed
			TESTMOD_POWERDOWN = 1'b1;
			TESTMOD_MODE = {1'b1, iface_reg[1:0]};
		end
		FREQ_COMP_OUT_EN = adc_test_reg[POS_FREQ_COMP_EN];
		SIGMA_DELTA_DITHER_EN = adc_test_reg[POS_DITHER_EN];
		INTEGRATOR_CHOP_OFF = adc_test_reg[POS_CHOP_OFF];
		FEEDBACK_SHAPING_OFF = adc_test_reg[POS_SHAPING_OFF];
		COMMON_MODE_ROTATION_OFF = adc_test_reg[POS_CM_ROTATION_OFF];
		ADC_ROTATION_POS = rot_pos(adc_test_reg[1:0], rot_step_reg);
		ADC_CLK_OUT = adc_clk_reg;
		// Values pass only under override so normal AGC stays in charge
		VGA_OVERRIDE_EN = vga_coupler_reg[POS_VGA_OVERRIDE];
		COUPLER_ONE_VALUE = VGA_OVERRIDE_EN & vga_coupler_reg[POS_COUPLER_ONE];
		COUPLER_TWO_VALUE = VGA_OVERRIDE_EN ? vga_coupler_reg[1:0] : 2'h0;
		GAIN_STAGE_ONE_VALUE = VGA_OVERRIDE_EN ? vga_stage_reg[5:4] : 2'h0;
		GAIN_STAGE_TWO_VALUE = VGA_OVERRIDE_EN ? vga_stage_reg[3:2] : 2'h0;
		GAIN_STAGE_THREE_VALUE = VGA_OVERRIDE_EN ? vga_stage_reg[1:0] : 2'h0;
	end

	// Pin muxing: ADC sample output takes over all three pins
	always_comb begin
		LOCK_PIN_O = sample_out ? ADC_SAMPLE[1] : LOCK_NORMAL;
		LOCK_PIN_OE = sample_out | LOCK_NORMAL_OE;
		DATA_CLOCK_PIN_O = sample_out ? adc_clk_reg : DATA_CLOCK_PIN_NORMAL;
		DATA_CLOCK_PIN_OE = sample_out | DATA_CLOCK_PIN_NORMAL_OE;
		SERIAL_DATA_PIN_O = sample_out ? ADC_SAMPLE[0] : DATA_NORMAL;
		SERIAL_DATA_PIN_OE = sample_out | DATA_NORMAL_OE;
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Write then answer
	sequence s_write_commit;
		aw_held_reg && w_held_reg && !bvalid_reg;
	endsequence
	AST_RESET_DEFAULTS: assert property ($fell(RST) |-> SIGMA_DELTA_DITHER_EN && !PUMP_NORMAL_OFF && !MIXER_DC_TEST_EN)
		else $error("reset defaults wrong");
	AST_MIXER_POLARITY: assert property (MIXER_DC_TEST_EN |-> MIXER_I_POSITIVE == cp_mixer_reg[4] && MIXER_Q_POSITIVE == cp_mixer_reg[3])
		else $error("mixer polarity mismatch");
	AST_MIXER_IDLE: assert property (!cp_mixer_reg[2] |-> !MIXER_DC_TEST_EN && !MIXER_I_POSITIVE)
		else $error("mixer driven without test");
	AST_TESTMOD_FORCED: assert property (!TESTMOD_TO_FILTER_EN && !TESTMOD_TO_ADC_EN |-> TESTMOD_POWERDOWN && TESTMOD_MODE[2])
		else $error("test module not forced off");
	AST_TESTMOD_FOLLOW: assert property ((TESTMOD_TO_FILTER_EN || TESTMOD_TO_ADC_EN) |-> {TESTMOD_POWERDOWN, TESTMOD_MODE} == iface_reg)
		else $error("test module not following interface");
	AST_SAMPLE_PINS: assert property (adc_test_reg[5] |-> LOCK_PIN_O == ADC_SAMPLE[1] && SERIAL_DATA_PIN_O == ADC_SAMPLE[0] && DATA_CLOCK_PIN_O == ADC_CLK_OUT)
		else $error("sample pins wrong");
	AST_ROT_FIXED: assert property (adc_test_reg[1:0] == 2'h2 |-> ADC_ROTATION_POS == 2'h0)
		else $error("fixed rotation moved");
	AST_ROT_ALT: assert property (adc_test_reg[1:0] == 2'h3 |-> ADC_ROTATION_POS[0] == 1'b0)
		else $error("alternate rotation off pattern");
	AST_WRITE_READBACK: assert property (s_write_commit ##0 (aw_idx_reg == IDX_CP_MIXER_TEST_CTRL && !aw_bad_reg && w_lane_reg)
		|=> cp_mixer_reg == $past(w_data_reg) && AXI_RESP.bvalid)
		else $error("write not stored");
	AST_STATUS_READ: assert property (AXI_REQ.arvalid && AXI_RESP.arready && ar_idx == IDX_PIN_STATUS && rd_hit
		|=> AXI_RESP.rdata[2:0] == $past({LOCK_PIN_I, DATA_CLOCK_PIN_I, SERIAL_DATA_PIN_I}))
		else $error("status read wrong");
	AST_VGA_GATED: assert property (!VGA_OVERRIDE_EN |-> !COUPLER_ONE_VALUE && COUPLER_TWO_VALUE == 2'h0 && GAIN_STAGE_ONE_VALUE == 2'h0)
		else $error("vga values leak without override");
endmodule : rftor_regs

// ---- rftor_regs_tb.sv ----
// Self-checking testbench of the RF test override register bank
`timescale 1ns/100ps
module rftor_regs_tb import rftor_pkg::*;;
	localparam int HP = 4; // ADC clock half period, kept short
	// Clock, reset and bus
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	rftor_axi_req_type AXI_REQ = '0;
	rftor_axi_resp_type AXI_RESP;
	// Design outputs
	logic PUMP_NORMAL_OFF, PUMP_FORCE_UP, PUMP_FORCE_DOWN, MIXER_DC_TEST_EN, MIXER_I_POSITIVE, MIXER_Q_POSITIVE;
	logic TESTMOD_TO_FILTER_EN, TESTMOD_TO_ADC_EN, TESTMOD_POWERDOWN, FREQ_COMP_OUT_EN, SIGMA_DELTA_DITHER_EN;
	logic INTEGRATOR_CHOP_OFF, FEEDBACK_SHAPING_OFF, COMMON_MODE_ROTATION_OFF, ADC_CLK_OUT, VGA_OVERRIDE_EN;
	logic COUPLER_ONE_VALUE, LOCK_PIN_O, LOCK_PIN_OE, DATA_CLOCK_PIN_O, DATA_CLOCK_PIN_OE;
	logic SERIAL_DATA_PIN_O, SERIAL_DATA_PIN_OE;
	logic [2:0] TESTMOD_MODE;
	logic [1:0] ADC_ROTATION_POS, COUPLER_TWO_VALUE, GAIN_STAGE_ONE_VALUE, GAIN_STAGE_TWO_VALUE, GAIN_STAGE_THREE_VALUE;
	// Bench-driven inputs
	logic [1:0] ADC_SAMPLE = 2'h0;
	logic LOCK_NORMAL = 1'b0, LOCK_NORMAL_OE = 1'b0, DATA_CLOCK_PIN_NORMAL = 1'b0, DATA_CLOCK_PIN_NORMAL_OE = 1'b0;
	logic DATA_NORMAL = 1'b0, DATA_NORMAL_OE = 1'b0;
	logic [2:0] ext_pins = 3'h0; // Outside drivers: lock, clock, data
	logic LOCK_PIN_I, DATA_CLOCK_PIN_I, SERIAL_DATA_PIN_I;
	int error_cnt = 0;
	int cmp_count = 0;

	// Wire level: the design wins while it drives, else the outside driver
	assign LOCK_PIN_I = LOCK_PIN_OE ? LOCK_PIN_O : ext_pins[2];
	assign DATA_CLOCK_PIN_I = DATA_CLOCK_PIN_OE ? DATA_CLOCK_PIN_O : ext_pins[1];
	assign SERIAL_DATA_PIN_I = SERIAL_DATA_PIN_OE ? SERIAL_DATA_PIN_O : ext_pins[0];

	// 40 MHz clock
	always #12.5 CLK_SYS = ~CLK_SYS;

	rftor_regs #(.ADC_HALF_PERIOD(HP)) i_rftor_regs (
		.CLK_SYS, .RST, .AXI_REQ, .AXI_RESP, .PUMP_NORMAL_OFF, .PUMP_FORCE_UP, .PUMP_FORCE_DOWN,
		.MIXER_DC_TEST_EN, .MIXER_I_POSITIVE, .MIXER_Q_POSITIVE, .TESTMOD_TO_FILTER_EN, .TESTMOD_TO_ADC_EN,
		.TESTMOD_POWERDOWN, .TESTMOD_MODE, .FREQ_COMP_OUT_EN, .SIGMA_DELTA_DITHER_EN, .INTEGRATOR_CHOP_OFF,
		.FEEDBACK_SHAPING_OFF, .COMMON_MODE_ROTATION_OFF, .ADC_ROTATION_POS, .ADC_CLK_OUT, .ADC_SAMPLE,
		.VGA_OVERRIDE_EN, .COUPLER_ONE_VALUE, .COUPLER_TWO_VALUE, .GAIN_STAGE_ONE_VALUE, .GAIN_STAGE_TWO_VALUE,
		.GAIN_STAGE_THREE_VALUE, .LOCK_NORMAL, .LOCK_NORMAL_OE, .DATA_CLOCK_PIN_NORMAL, .DATA_CLOCK_PIN_NORMAL_OE, .DATA_NORMAL,
		.DATA_NORMAL_OE, .LOCK_PIN_I, .LOCK_PIN_O, .LOCK_PIN_OE, .DATA_CLOCK_PIN_I, .DATA_CLOCK_PIN_O,
		.DATA_CLOCK_PIN_OE, .SERIAL_DATA_PIN_I, .SERIAL_DATA_PIN_O, .SERIAL_DATA_PIN_OE
	);

	// Value compare; four-state so unknowns never match
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, got);
		end
	endtask : chk

	// Bus write; handshakes judged at the falling edge, acted on at the next rising one
	task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r, input logic [3:0] s);
		logic aw_t, w_t, b_t;
		AXI_REQ.awvalid <= 1'b1;
		AXI_REQ.awaddr <= a;
		AXI_REQ.wvalid <= 1'b1;
		AXI_REQ.wdata <= {24'h0, d};
		AXI_REQ.wstrb <= s;
		AXI_REQ.bready <= 1'b1;
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge CLK_SYS);
			aw_t = AXI_REQ.awvalid & AXI_RESP.awready;
			w_t = AXI_REQ.wvalid & AXI_RESP.wready;
			b_t = AXI_RESP.bvalid & AXI_REQ.bready;
			r = AXI_RESP.bresp;
			@(posedge CLK_SYS);
			if (aw_t) AXI_REQ.awvalid <= 1'b0;
			if (w_t) AXI_REQ.wvalid <= 1'b0;
		end
		AXI_REQ.bready <= 1'b0;
		@(posedge CLK_SYS);
	endtask : axi_write

	// Bus read
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		AXI_REQ.arvalid <= 1'b1;
		AXI_REQ.araddr <= a;
		AXI_REQ.rready <= 1'b1;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge CLK_SYS);
			ar_t = AXI_REQ.arvalid & AXI_RESP.arready;
			r_t = AXI_RESP.rvalid & AXI_REQ.rready;
			d = AXI_RESP.rdata;
			r = AXI_RESP.rresp;
			@(posedge CLK_SYS);
			if (ar_t) AXI_REQ.arvalid <= 1'b0;
		end
		AXI_REQ.rready <= 1'b0;
		@(posedge CLK_SYS);
	endtask : axi_read

	// Write expecting an OKAY answer
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, d, r, 4'hF);
		chk("write response", RESP_OKAY, r);
	endtask : wr

	// Read expecting OKAY and a given byte
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		chk("read data", {24'h0, exp}, d);
		chk("read response", RESP_OKAY, r);
	endtask : rd_chk

	// Expected next rotation position per mode
	function automatic logic [1:0] rot_next(input logic [1:0] m, input logic [1:0] p);
		case (m)
			2'h0: rot_next = p + 2'h1;
			2'h1: rot_next = (p == 2'h0) ? 2'h2 : (p == 2'h2) ? 2'h3 : (p == 2'h3) ? 2'h1 : 2'h0;
			2'h2: rot_next = 2'h0;
			default: rot_next = (p == 2'h0) ? 2'h2 : 2'h0;
		endcase
	endfunction : rot_next

	// Position mid-period after a rising ADC clock, away from the step
	task automatic rot_pos(output logic [1:0] p);
		logic last;
		do begin
			last = ADC_CLK_OUT;
			@(negedge CLK_SYS);
		end while (!(ADC_CLK_OUT === 1'b1 && last === 1'b0));
		repeat (HP) @(negedge CLK_SYS);
		p = ADC_ROTATION_POS;
	endtask : rot_pos

	// Defaults at the bus and at the analog controls
	task automatic t_reset;
		rd_chk(12'h090, 8'h00);
		rd_chk(12'h094, 8'h40);
		rd_chk(12'h098, 8'h00);
		rd_chk(12'h09C, 8'h00);
		rd_chk(12'h0A0, 8'h00);
		chk("dither", 1'b1, SIGMA_DELTA_DITHER_EN);
		chk("pump", 3'h0, {PUMP_NORMAL_OFF, PUMP_FORCE_UP, PUMP_FORCE_DOWN});
		chk("test module", 4'hC, {TESTMOD_POWERDOWN, TESTMOD_MODE});
		chk("mixer", 3'h0, {MIXER_DC_TEST_EN, MIXER_I_POSITIVE, MIXER_Q_POSITIVE});
		chk("adc off bits", 4'h0, {FREQ_COMP_OUT_EN, INTEGRATOR_CHOP_OFF, FEEDBACK_SHAPING_OFF, COMMON_MODE_ROTATION_OFF});
		$display("test reset values done");
	endtask : t_reset

	// Every polarity code with varied pump bits, then mixer test off
	task automatic t_mixer;
		logic [7:0] d;
		for (int p = 0; p < 4; p++) begin
			d = {p[1:0], ~p[1], p[1:0], 3'b100};
			wr(12'h090, d);
			chk("pump", d[7:5], {PUMP_NORMAL_OFF, PUMP_FORCE_UP, PUMP_FORCE_DOWN});
			chk("mixer iq", {1'b1, d[4:3]}, {MIXER_DC_TEST_EN, MIXER_I_POSITIVE, MIXER_Q_POSITIVE});
			rd_chk(12'h090, d);
		end
		wr(12'h090, 8'h18);
		chk("mixer off", 3'h0, {MIXER_DC_TEST_EN, MIXER_I_POSITIVE, MIXER_Q_POSITIVE});
		$display("test mixer and pump done");
	endtask : t_mixer

	// Each route combination against a fixed interface value
	task automatic t_route;
		wr(12'h0A0, 8'h03);
		for (int r = 0; r < 4; r++) begin
			wr(12'h090, r[7:0]);
			chk("routes", r[1:0], {TESTMOD_TO_FILTER_EN, TESTMOD_TO_ADC_EN});
			chk("test module", (r == 0) ? 4'hF : 4'h3, {TESTMOD_POWERDOWN, TESTMOD_MODE});
		end
		wr(12'h090, 8'h00);
		$display("test module routing done");
	endtask : t_route

	// ADC controls, rotation orders and sample output on the pins
	task automatic t_adc;
		logic [1:0] prev, cur;
		wr(12'h094, 8'h9C);
		chk("freq comp and dither", 2'h2, {FREQ_COMP_OUT_EN, SIGMA_DELTA_DITHER_EN});
		chk("chop shaping rotation", 3'h7, {INTEGRATOR_CHOP_OFF, FEEDBACK_SHAPING_OFF, COMMON_MODE_ROTATION_OFF});
		for (int m = 0; m < 4; m++) begin
			wr(12'h094, m[7:0]);
			rot_pos(prev);
			for (int k = 0; k < 6; k++) begin
				rot_pos(cur);
				// First step after a mode change may still follow the old order
				if (k > 0 && !(m == 3 && prev[0])) chk("rotation", rot_next(m[1:0], prev), cur);
				prev = cur;
			end
			@(posedge CLK_SYS);
		end
		wr(12'h094, 8'h20);
		for (int s = 0; s < 4; s++) begin
			ADC_SAMPLE <= s[1:0];
			@(negedge CLK_SYS);
			chk("pins out", {s[1], ADC_CLK_OUT, s[0]}, {LOCK_PIN_O, DATA_CLOCK_PIN_O, SERIAL_DATA_PIN_O});
			chk("pins oe", 3'h7, {LOCK_PIN_OE, DATA_CLOCK_PIN_OE, SERIAL_DATA_PIN_OE});
			@(posedge CLK_SYS);
		end
		LOCK_NORMAL <= 1'b1;
		LOCK_NORMAL_OE <= 1'b1;
		DATA_CLOCK_PIN_NORMAL <= 1'b1;
		DATA_CLOCK_PIN_NORMAL_OE <= 1'b1;
		DATA_NORMAL <= 1'b1;
		wr(12'h094, 8'h00);
		chk("pins normal", 6'h3E, {LOCK_PIN_O, LOCK_PIN_OE, DATA_CLOCK_PIN_O, DATA_CLOCK_PIN_OE,
			SERIAL_DATA_PIN_O, SERIAL_DATA_PIN_OE});
		$display("test adc controls done");
	endtask : t_adc

	// Override values, reserved bits, override off
	task automatic t_vga;
		wr(12'h098, 8'hFF);
		rd_chk(12'h098, 8'h0F);
		wr(12'h09C, 8'hDB);
		rd_chk(12'h09C, 8'h1B);
		chk("couplers", 4'hF, {VGA_OVERRIDE_EN, COUPLER_ONE_VALUE, COUPLER_TWO_VALUE});
		chk("stages", 6'h1B, {GAIN_STAGE_ONE_VALUE, GAIN_STAGE_TWO_VALUE, GAIN_STAGE_THREE_VALUE});
		wr(12'h098, 8'h0A);
		chk("couplers", 4'hA, {VGA_OVERRIDE_EN, COUPLER_ONE_VALUE, COUPLER_TWO_VALUE});
		wr(12'h098, 8'h07);
		chk("vga off", 10'h000, {VGA_OVERRIDE_EN, COUPLER_ONE_VALUE, COUPLER_TWO_VALUE,
			GAIN_STAGE_ONE_VALUE, GAIN_STAGE_TWO_VALUE, GAIN_STAGE_THREE_VALUE});
		$display("test vga override done");
	endtask : t_vga

	// Live pin levels and unmapped places
	task automatic t_status;
		logic [31:0] d;
		logic [1:0] r;
		LOCK_NORMAL_OE <= 1'b0;
		DATA_CLOCK_PIN_NORMAL_OE <= 1'b0;
		ext_pins <= 3'h5;
		@(posedge CLK_SYS);
		rd_chk(12'h100, 8'h05);
		ext_pins <= 3'h2;
		@(posedge CLK_SYS);
		rd_chk(12'h100, 8'h02);
		axi_read(12'h104, d, r);
		chk("unmapped read", RESP_SLVERR, r);
		axi_write(12'h0A4, 8'h55, r, 4'hF);
		chk("unmapped write", RESP_SLVERR, r);
		// Lane zero masked: answer OKAY, interface value kept
		axi_write(12'h0A0, 8'h0C, r, 4'h0);
		chk("masked write", RESP_OKAY, r);
		rd_chk(12'h0A0, 8'h03);
		// Status is read-only: write answered OKAY, pins still shown
		wr(12'h100, 8'hFF);
		rd_chk(12'h100, 8'h02);
		$display("test status and unmapped done");
	endtask : t_status

	// Counts, verdict and stop
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// Main sequence, with a second reset after the registers were changed
	initial begin
		repeat (16) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		t_reset();
		t_mixer();
		t_route();
		t_adc();
		t_vga();
		t_status();
		RST <= 1'b1;
		@(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		t_reset();
		end_of_test();
	end

	// Watchdog: the run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		error_cnt++;
		$display("unexpected run length: expected end within 20000 cycles, seen none");
		end_of_test();
	end
endmodule : rftor_regs_tb
